// *** verilog/dmc_pkg.sv ***
package dmc_pkg;
  localparam int unsigned DMC_AW = 32;
  localparam int unsigned DMC_DW = 32;
  localparam int unsigned DMC_BE_W = 4;
  localparam logic [3:0] DMC_BE_FULL = 4'hf;
  localparam int unsigned DMC_D_IDX_W = 8;
  localparam int unsigned DMC_I_IDX_W = 6;
  localparam int unsigned DMC_I_LINE_WORDS = 4;
  localparam logic [1:0] DMC_BURST_LAST = 2'h3;
  localparam logic [1:0] DMC_SINGLE_LAST = 2'h0;
  localparam logic [2:0] DMC_SEG_CACHED = 3'h4;
  localparam logic [2:0] DMC_SEG_UNCACHED = 3'h5;
  localparam logic [31:0] DMC_MAP_OFFSET = 32'h4000_0000;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_MERGE = 3'h1,
    D_MEMWR = 3'h3,
    D_FILL = 3'h2,
    D_EVICT = 3'h6,
    D_UNC = 3'h7
  } dmc_dstate_t;

  typedef enum logic [1:0] {
    I_IDLE = 2'h0,
    I_FILL = 2'h1,
    I_UNC = 2'h3
  } dmc_istate_t;

  function automatic logic [DMC_DW-1:0] dmc_merge(input logic [DMC_DW-1:0] old_w,
                                                  input logic [DMC_DW-1:0] new_w,
                                                  input logic [DMC_BE_W-1:0] be);
    logic [DMC_DW-1:0] r;
    r = old_w;
    for (int b = 0; b < DMC_BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// *** verilog/dmc_xlate.sv ***
`timescale 1ns/1ps
module dmc_xlate (
  input wire logic [dmc_pkg::DMC_AW-1:0] vaddr_i,
  output logic [dmc_pkg::DMC_AW-1:0] paddr_o,
  output logic cached_o
);
  import dmc_pkg::*;

  always_comb begin
    unique case (vaddr_i[31:29])
      DMC_SEG_CACHED: begin
        paddr_o = {3'h0, vaddr_i[28:0]};
        cached_o = 1'h1;
      end
      DMC_SEG_UNCACHED: begin
        paddr_o = {3'h0, vaddr_i[28:0]};
        cached_o = 1'h0;
      end
      default: begin
        paddr_o = vaddr_i + DMC_MAP_OFFSET;
        cached_o = 1'h1;
      end
    endcase
  end
endmodule

// *** verilog/dmc_icache.sv ***
`timescale 1ns/1ps
module dmc_icache #(
  parameter int unsigned IDX_W = dmc_pkg::DMC_I_IDX_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [dmc_pkg::DMC_AW-1:0] rd_pa_i,
  output logic hit_o,
  output logic [dmc_pkg::DMC_DW-1:0] rdata_o,
  input wire logic wr_en_i,
  input wire logic [dmc_pkg::DMC_AW-1:0] wr_pa_i,
  input wire logic [dmc_pkg::DMC_DW-1:0] wr_data_i,
  input wire logic wr_first_i,
  input wire logic wr_last_i
);
  import dmc_pkg::*;
  localparam int unsigned DEPTH = 1 << IDX_W;
  localparam int unsigned TAG_W = DMC_AW - IDX_W - 4;

  logic [TAG_W-1:0] tag_q [DEPTH];
  logic [DMC_DW-1:0] data_q [DEPTH*DMC_I_LINE_WORDS];
  logic [DEPTH-1:0] val_q;
  logic [DEPTH-1:0] val_d;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] wr_idx;

  assign rd_idx = rd_pa_i[IDX_W+3:4];
  assign wr_idx = wr_pa_i[IDX_W+3:4];

  always_comb begin
    hit_o = val_q[rd_idx] && (tag_q[rd_idx] == rd_pa_i[DMC_AW-1:IDX_W+4]); // RULE14
    rdata_o = data_q[{rd_idx, rd_pa_i[3:2]}]; // RULE15
    val_d = val_q;
    if (wr_en_i && wr_first_i) begin
      val_d[wr_idx] = 1'h0; // RULE4
    end
    if (wr_en_i && wr_last_i) begin
      val_d[wr_idx] = 1'h1; // RULE16
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      val_q <= '0;
    end else begin
      val_q <= val_d;
    end
  end

  // storage arrays carry no reset; valid bits guard them
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      data_q[{wr_idx, wr_pa_i[3:2]}] <= wr_data_i;
    end
    if (wr_en_i && wr_last_i) begin
      tag_q[wr_idx] <= wr_pa_i[DMC_AW-1:IDX_W+4];
    end
  end
endmodule

// *** verilog/dmc_cache_ctrl.sv ***
// How it works
// RULE1 - cached load hit returns cached word
// RULE2 - load miss reads memory, installs, then acknowledges
// RULE3 - uncached load goes to memory, cache untouched
// RULE4 - refill replaces previous contents at index
// RULE5 - write-back store stays in cache until replaced
// RULE6 - each data line has a modified flag
// RULE7 - cached full-word store always writes line; code writes only memory when the index is locked by another address
// RULE8 - partial store hit merges bytes into line
// RULE9 - partial store miss writes memory only
// RULE10 - write-through stores always also go to memory
// RULE11 - write-back memory write deferred to replace/flush
// RULE12 - uncached store bypasses cache completely
// RULE13 - translate address before indexing both caches
// RULE14 - direct mapped, hit on physical tag match
// RULE15 - instruction lines four words, data lines one
// RULE16 - line marked usable only after full fill
// RULE17 - option: data miss refills four lines; code does so only in write-through mode, not write-back
// RULE18 - refill overwrites without saving old data
// RULE19 - partial store costs one extra clock
// RULE20 - single-clock hits, instruction and data parallel
// RULE21 - locked line never chosen for refill
// RULE22 - modified victim written to memory before refill
`timescale 1ns/1ps
module dmc_cache_ctrl #(
  parameter int unsigned D_IDX_W = dmc_pkg::DMC_D_IDX_W,
  parameter int unsigned I_IDX_W = dmc_pkg::DMC_I_IDX_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic d_req_i,
  input wire logic d_we_i,
  input wire logic d_flush_i,
  input wire logic [dmc_pkg::DMC_BE_W-1:0] d_be_i,
  input wire logic [dmc_pkg::DMC_AW-1:0] d_vaddr_i,
  input wire logic [dmc_pkg::DMC_DW-1:0] d_wdata_i,
  input wire logic d_wb_mode_i,
  input wire logic d_lock_i,
  input wire logic d_fill4_i,
  output logic d_ack_o,
  output logic [dmc_pkg::DMC_DW-1:0] d_rdata_o,
  input wire logic i_req_i,
  input wire logic [dmc_pkg::DMC_AW-1:0] i_vaddr_i,
  output logic i_ack_o,
  output logic [dmc_pkg::DMC_DW-1:0] i_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [dmc_pkg::DMC_AW-1:0] mem_addr_o,
  output logic [dmc_pkg::DMC_BE_W-1:0] mem_be_o,
  output logic [dmc_pkg::DMC_DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [dmc_pkg::DMC_DW-1:0] mem_rdata_i
);
  import dmc_pkg::*;
  localparam int unsigned D_DEPTH = 1 << D_IDX_W;
  localparam int unsigned TAG_W = DMC_AW - D_IDX_W - 2;

  // data cache storage
  logic [TAG_W-1:0] dc_tag_q [D_DEPTH];
  logic [DMC_DW-1:0] dc_data_q [D_DEPTH];
  logic [D_DEPTH-1:0] dc_val_q;
  logic [D_DEPTH-1:0] dc_dirty_q;
  logic [D_DEPTH-1:0] dc_lock_q;
  logic [D_DEPTH-1:0] dc_val_d;
  logic [D_DEPTH-1:0] dc_dirty_d;
  logic [D_DEPTH-1:0] dc_lock_d;

  // data side request state
  dmc_dstate_t d_state_q, d_state_d;
  logic [DMC_AW-1:0] a_pa_q, a_pa_d;
  logic a_we_q, a_we_d;
  logic [DMC_BE_W-1:0] a_be_q, a_be_d;
  logic [DMC_DW-1:0] a_wdata_q, a_wdata_d;
  logic a_wb_q, a_wb_d;
  logic a_lock_q, a_lock_d;
  logic a_flush_q, a_flush_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] last_q, last_d;
  logic d_ack_q, d_ack_d;
  logic [DMC_DW-1:0] d_rdata_q, d_rdata_d;

  // instruction side state
  dmc_istate_t i_state_q, i_state_d;
  logic [DMC_AW-1:0] i_pa_q, i_pa_d;
  logic [1:0] i_cnt_q, i_cnt_d;
  logic i_ack_q, i_ack_d;
  logic [DMC_DW-1:0] i_rdata_q, i_rdata_d;

  // shared memory port
  logic mem_req_q, mem_req_d;
  logic mem_we_q, mem_we_d;
  logic [DMC_AW-1:0] mem_addr_q, mem_addr_d;
  logic [DMC_BE_W-1:0] mem_be_q, mem_be_d;
  logic [DMC_DW-1:0] mem_wdata_q, mem_wdata_d;
  logic mem_own_q, mem_own_d;

  logic [DMC_AW-1:0] x_pa;
  logic x_cached;
  logic [DMC_AW-1:0] xi_pa;
  logic xi_cached;
  logic [DMC_AW-1:0] fill_pa;
  logic [DMC_AW-1:0] lk_pa;
  logic [D_IDX_W-1:0] lk_idx;
  logic [TAG_W-1:0] lk_tag;
  logic lk_hit;
  logic lk_other;
  logic lk_dirty;
  logic lk_dirty_other;
  logic lk_lock_other;
  logic req_word;
  logic wr_en;
  logic [DMC_DW-1:0] wr_data;
  logic wr_val;
  logic wr_dirty;
  logic wr_lock;
  logic d_want;
  logic d_m_we;
  logic [DMC_AW-1:0] d_m_addr;
  logic [DMC_BE_W-1:0] d_m_be;
  logic [DMC_DW-1:0] d_m_data;
  logic d_done;
  logic i_done;
  logic ic_hit;
  logic [DMC_DW-1:0] ic_rdata;
  logic ic_wr;

  dmc_xlate u_dx (
    .vaddr_i(d_vaddr_i),
    .paddr_o(x_pa),
    .cached_o(x_cached)
  );

  dmc_xlate u_ix (
    .vaddr_i(i_vaddr_i),
    .paddr_o(xi_pa),
    .cached_o(xi_cached)
  );

  dmc_icache #(
    .IDX_W(I_IDX_W)
  ) u_ic (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rd_pa_i(xi_pa),
    .hit_o(ic_hit),
    .rdata_o(ic_rdata),
    .wr_en_i(ic_wr),
    .wr_pa_i({i_pa_q[31:4], i_cnt_q, 2'h0}),
    .wr_data_i(mem_rdata_i),
    .wr_first_i(i_cnt_q == 2'h0),
    .wr_last_i(i_cnt_q == 2'h3)
  );

  assign d_done = mem_req_q && mem_ack_i && !mem_own_q;
  assign i_done = mem_req_q && mem_ack_i && mem_own_q;

  // data cache lookup; one index per cycle, shared by read and write
  always_comb begin
    if (last_q != DMC_SINGLE_LAST) begin
      fill_pa = {a_pa_q[31:4], cnt_q, 2'h0}; // RULE17
    end else begin
      fill_pa = {a_pa_q[31:2], 2'h0};
    end
    if (d_state_q == D_IDLE) begin
      lk_pa = x_pa; // RULE13
    end else if (d_state_q == D_FILL) begin
      lk_pa = fill_pa;
    end else begin
      lk_pa = a_pa_q;
    end
    lk_idx = lk_pa[D_IDX_W+1:2];
    lk_tag = lk_pa[DMC_AW-1:D_IDX_W+2];
    lk_hit = dc_val_q[lk_idx] && (dc_tag_q[lk_idx] == lk_tag); // RULE14
    lk_other = dc_val_q[lk_idx] && !lk_hit;
    lk_dirty = dc_val_q[lk_idx] && dc_dirty_q[lk_idx];
    lk_dirty_other = lk_other && dc_dirty_q[lk_idx];
    lk_lock_other = lk_other && dc_lock_q[lk_idx]; // RULE21
    req_word = fill_pa[31:2] == a_pa_q[31:2];
  end

  // data side sequencing
  always_comb begin
    d_state_d = d_state_q;
    a_pa_d = a_pa_q;
    a_we_d = a_we_q;
    a_be_d = a_be_q;
    a_wdata_d = a_wdata_q;
    a_wb_d = a_wb_q;
    a_lock_d = a_lock_q;
    a_flush_d = a_flush_q;
    cnt_d = cnt_q;
    last_d = last_q;
    d_ack_d = 1'h0;
    d_rdata_d = d_rdata_q;
    wr_en = 1'h0;
    wr_data = a_wdata_q;
    wr_val = 1'h1;
    wr_dirty = 1'h0;
    wr_lock = 1'h0;
    unique case (d_state_q)
      D_IDLE: begin
        if (d_req_i && !d_ack_q) begin
          a_pa_d = x_pa;
          a_we_d = d_we_i;
          a_be_d = d_be_i;
          a_wdata_d = d_wdata_i;
          a_wb_d = d_wb_mode_i;
          a_lock_d = d_lock_i;
          a_flush_d = d_flush_i;
          cnt_d = 2'h0;
          // bursts only in write-through; modified neighbours are skipped, so none needs saving
          last_d = (d_fill4_i && !d_wb_mode_i) ? DMC_BURST_LAST : DMC_SINGLE_LAST; // RULE17
          if (d_flush_i) begin
            if (lk_dirty) begin
              d_state_d = D_EVICT; // RULE11
            end else begin
              wr_en = 1'h1;
              wr_val = 1'h0;
              d_ack_d = 1'h1;
            end
          end else if (!x_cached) begin
            d_state_d = d_we_i ? D_MEMWR : D_UNC; // RULE3 RULE12
          end else if (!d_we_i) begin
            if (lk_hit) begin
              d_rdata_d = dc_data_q[lk_idx]; // RULE1 RULE20
              d_ack_d = 1'h1;
            end else if (lk_lock_other) begin
              d_state_d = D_UNC; // RULE21
            end else if (lk_dirty_other) begin
              d_state_d = D_EVICT; // RULE22
            end else begin
              d_state_d = D_FILL; // RULE2
            end
          end else if (d_be_i != DMC_BE_FULL) begin
            d_state_d = D_MERGE; // RULE19
          end else if (lk_lock_other) begin
            d_state_d = D_MEMWR; // RULE21
          end else if (lk_dirty_other) begin
            d_state_d = D_EVICT; // RULE22
          end else begin
            wr_en = 1'h1; // RULE7
            wr_data = d_wdata_i;
            wr_dirty = d_wb_mode_i; // RULE6
            wr_lock = lk_hit && dc_lock_q[lk_idx];
            if (d_wb_mode_i) begin
              d_ack_d = 1'h1; // RULE5
            end else begin
              d_state_d = D_MEMWR; // RULE10
            end
          end
        end
      end
      D_MERGE: begin
        if (lk_hit) begin
          wr_en = 1'h1; // RULE8
          wr_data = dmc_merge(dc_data_q[lk_idx], a_wdata_q, a_be_q);
          wr_dirty = dc_dirty_q[lk_idx] || a_wb_q; // RULE6
          wr_lock = dc_lock_q[lk_idx];
        end
        if (lk_hit && a_wb_q) begin
          d_ack_d = 1'h1; // RULE5
          d_state_d = D_IDLE;
        end else begin
          d_state_d = D_MEMWR; // RULE9 RULE10
        end
      end
      D_EVICT: begin
        if (d_done) begin
          wr_en = 1'h1;
          if (a_we_q && !a_flush_q) begin
            wr_dirty = a_wb_q; // RULE7
            d_state_d = a_wb_q ? D_IDLE : D_MEMWR;
            d_ack_d = a_wb_q;
          end else begin
            wr_val = 1'h0; // RULE4
            d_state_d = a_flush_q ? D_IDLE : D_FILL;
            d_ack_d = a_flush_q;
          end
        end
      end
      D_FILL: begin
        if (d_done) begin
          // skip neighbours that are modified or pinned to another address
          if (!lk_dirty && !lk_lock_other) begin
            wr_en = 1'h1; // RULE4 RULE18
            wr_data = mem_rdata_i;
            wr_lock = a_lock_q && req_word;
          end
          if (req_word) begin
            d_rdata_d = mem_rdata_i;
          end
          if (cnt_q == last_q) begin
            d_ack_d = 1'h1; // RULE2 RULE16
            d_state_d = D_IDLE;
          end
          cnt_d = cnt_q + 2'h1;
        end
      end
      D_UNC: begin
        if (d_done) begin
          d_rdata_d = mem_rdata_i; // RULE3
          d_ack_d = 1'h1;
          d_state_d = D_IDLE;
        end
      end
      D_MEMWR: begin
        if (d_done) begin
          d_ack_d = 1'h1;
          d_state_d = D_IDLE;
        end
      end
      default: begin
        d_state_d = D_IDLE;
      end
    endcase
  end

  // data array updates
  always_comb begin
    dc_val_d = dc_val_q;
    dc_dirty_d = dc_dirty_q;
    dc_lock_d = dc_lock_q;
    if (wr_en) begin
      dc_val_d[lk_idx] = wr_val;
      dc_dirty_d[lk_idx] = wr_val && wr_dirty;
      dc_lock_d[lk_idx] = wr_val && wr_lock;
    end
  end

  // memory operation wanted by the data side
  always_comb begin
    d_want = 1'h1;
    d_m_we = 1'h0;
    d_m_addr = {a_pa_q[31:2], 2'h0};
    d_m_be = DMC_BE_FULL;
    d_m_data = a_wdata_q;
    unique case (d_state_q)
      D_EVICT: begin
        d_m_we = 1'h1; // RULE22
        d_m_addr = {dc_tag_q[lk_idx], lk_idx, 2'h0};
        d_m_data = dc_data_q[lk_idx];
      end
      D_FILL: begin
        d_m_addr = fill_pa;
      end
      D_MEMWR: begin
        d_m_we = 1'h1; // RULE9 RULE10 RULE12
        d_m_be = a_be_q;
      end
      D_UNC: begin
        d_m_we = 1'h0;
      end
      default: begin
        d_want = 1'h0;
      end
    endcase
  end

  // instruction side sequencing, independent of the data side
  always_comb begin
    i_state_d = i_state_q;
    i_pa_d = i_pa_q;
    i_cnt_d = i_cnt_q;
    i_ack_d = 1'h0;
    i_rdata_d = i_rdata_q;
    ic_wr = 1'h0;
    unique case (i_state_q)
      I_IDLE: begin
        if (i_req_i && !i_ack_q) begin
          i_pa_d = xi_pa; // RULE13
          i_cnt_d = 2'h0;
          if (!xi_cached) begin
            i_state_d = I_UNC;
          end else if (ic_hit) begin
            i_rdata_d = ic_rdata; // RULE20
            i_ack_d = 1'h1;
          end else begin
            i_state_d = I_FILL;
          end
        end
      end
      I_FILL: begin
        if (i_done) begin
          ic_wr = 1'h1; // RULE15 RULE16
          if (i_cnt_q == i_pa_q[3:2]) begin
            i_rdata_d = mem_rdata_i;
          end
          if (i_cnt_q == 2'h3) begin
            i_ack_d = 1'h1;
            i_state_d = I_IDLE;
          end
          i_cnt_d = i_cnt_q + 2'h1;
        end
      end
      I_UNC: begin
        if (i_done) begin
          i_rdata_d = mem_rdata_i;
          i_ack_d = 1'h1;
          i_state_d = I_IDLE;
        end
      end
      default: begin
        i_state_d = I_IDLE;
      end
    endcase
  end

  // one memory word at a time; data side wins a tie
  always_comb begin
    mem_req_d = mem_req_q;
    mem_we_d = mem_we_q;
    mem_addr_d = mem_addr_q;
    mem_be_d = mem_be_q;
    mem_wdata_d = mem_wdata_q;
    mem_own_d = mem_own_q;
    if (!mem_req_q) begin
      if (d_want) begin
        mem_req_d = 1'h1;
        mem_we_d = d_m_we;
        mem_addr_d = d_m_addr;
        mem_be_d = d_m_be;
        mem_wdata_d = d_m_data;
        mem_own_d = 1'h0;
      end else if (i_state_q != I_IDLE) begin
        mem_req_d = 1'h1;
        mem_we_d = 1'h0;
        mem_addr_d = (i_state_q == I_FILL) ? {i_pa_q[31:4], i_cnt_q, 2'h0} : {i_pa_q[31:2], 2'h0};
        mem_be_d = DMC_BE_FULL;
        mem_own_d = 1'h1;
      end
    end else if (mem_ack_i) begin
      mem_req_d = 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      d_state_q <= D_IDLE;
      a_pa_q <= '0;
      a_we_q <= 1'h0;
      a_be_q <= '0;
      a_wdata_q <= '0;
      a_wb_q <= 1'h0;
      a_lock_q <= 1'h0;
      a_flush_q <= 1'h0;
      cnt_q <= 2'h0;
      last_q <= DMC_SINGLE_LAST;
      d_ack_q <= 1'h0;
      d_rdata_q <= '0;
      dc_val_q <= '0;
      dc_dirty_q <= '0;
      dc_lock_q <= '0;
      i_state_q <= I_IDLE;
      i_pa_q <= '0;
      i_cnt_q <= 2'h0;
      i_ack_q <= 1'h0;
      i_rdata_q <= '0;
      mem_req_q <= 1'h0;
      mem_we_q <= 1'h0;
      mem_addr_q <= '0;
      mem_be_q <= '0;
      mem_wdata_q <= '0;
      mem_own_q <= 1'h0;
    end else begin
      d_state_q <= d_state_d;
      a_pa_q <= a_pa_d;
      a_we_q <= a_we_d;
      a_be_q <= a_be_d;
      a_wdata_q <= a_wdata_d;
      a_wb_q <= a_wb_d;
      a_lock_q <= a_lock_d;
      a_flush_q <= a_flush_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      d_ack_q <= d_ack_d;
      d_rdata_q <= d_rdata_d;
      dc_val_q <= dc_val_d;
      dc_dirty_q <= dc_dirty_d;
      dc_lock_q <= dc_lock_d;
      i_state_q <= i_state_d;
      i_pa_q <= i_pa_d;
      i_cnt_q <= i_cnt_d;
      i_ack_q <= i_ack_d;
      i_rdata_q <= i_rdata_d;
      mem_req_q <= mem_req_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_be_q <= mem_be_d;
      mem_wdata_q <= mem_wdata_d;
      mem_own_q <= mem_own_d;
    end
  end

  // tag and data words need no reset: valid bits guard them
  always_ff @(posedge sys_clk_i) begin
    if (wr_en && wr_val) begin
      dc_tag_q[lk_idx] <= lk_tag;
      dc_data_q[lk_idx] <= wr_data;
    end
  end

  assign d_ack_o = d_ack_q;
  assign d_rdata_o = d_rdata_q;
  assign i_ack_o = i_ack_q;
  assign i_rdata_o = i_rdata_q;
  assign mem_req_o = mem_req_q;
  assign mem_we_o = mem_we_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_be_o = mem_be_q;
  assign mem_wdata_o = mem_wdata_q;
endmodule

// *** sim/dmc_mem_model.sv ***
`timescale 1ns/1ps
module dmc_mem_model (
  input wire logic sys_clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [31:0]];
  int lat = 0, wt = 0, nrd = 0, nwr = 0;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : (a ^ 32'h5a5a_0000);
  endfunction
  initial begin
    ack_o = 1'b0;
    rdata_o = 32'h0;
  end
  // released read bus toggles so a stale word never looks fresh
  always @(negedge sys_clk_i) begin
    logic [31:0] w;
    rdata_o = ~rdata_o;
    if (ack_o) begin
      ack_o = 1'b0;
      wt = 0;
    end else if (req_i && wt < lat) begin
      wt++;
    end else if (req_i) begin
      ack_o = 1'b1;
      w = rd(addr_i);
      if (we_i) begin
        for (int b = 0; b < 4; b++) begin
          if (be_i[b]) begin
            w[b*8 +: 8] = wdata_i[b*8 +: 8];
          end
        end
        mem[addr_i] = w;
        nwr++;
      end else begin
        rdata_o = w;
        nrd++;
      end
    end
  end
endmodule

// *** sim/dmc_cache_ctrl_chk.sv ***
`timescale 1ns/1ps
module dmc_cache_ctrl_chk (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic d_req_i,
  input wire logic d_we_i,
  input wire logic d_flush_i,
  input wire logic [3:0] d_be_i,
  input wire logic [31:0] d_vaddr_i,
  input wire logic d_wb_mode_i,
  input wire logic d_ack_o,
  input wire logic i_req_i,
  input wire logic [31:0] i_vaddr_i,
  input wire logic i_ack_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [3:0] mem_be_o
);
  import dmc_pkg::*;
  logic d_take, i_take, d_unc, i_unc;
  logic d_busy_q, i_busy_q, wbst_q, part_q;
  logic [31:0] pa_q, ipa_q;
  logic [3:0] be_q;
  function automatic logic [31:0] wpa(input logic [31:0] va);
    if (va[31:29] == DMC_SEG_CACHED || va[31:29] == DMC_SEG_UNCACHED) begin
      return {3'h0, va[28:2], 2'h0};
    end
    return (va + DMC_MAP_OFFSET) & 32'hffff_fffc;
  endfunction
  assign d_take = d_req_i && !d_busy_q && !d_ack_o;
  assign i_take = i_req_i && !i_busy_q && !i_ack_o;
  assign d_unc = d_vaddr_i[31:29] == DMC_SEG_UNCACHED;
  assign i_unc = i_vaddr_i[31:29] == DMC_SEG_UNCACHED;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      d_busy_q <= 1'b0;
      i_busy_q <= 1'b0;
      wbst_q <= 1'b0;
      part_q <= 1'b0;
      pa_q <= 32'h0;
      ipa_q <= 32'h0;
      be_q <= 4'h0;
    end else begin
      d_busy_q <= d_take || (d_busy_q && !d_ack_o);
      i_busy_q <= i_take || (i_busy_q && !i_ack_o);
      if (d_take) begin
        wbst_q <= d_we_i && !d_flush_i && d_wb_mode_i && !d_unc && d_be_i == DMC_BE_FULL;
        part_q <= d_we_i && !d_flush_i && d_be_i != DMC_BE_FULL;
        pa_q <= wpa(d_vaddr_i);
        be_q <= d_be_i;
      end
      if (i_take) begin
        ipa_q <= wpa(i_vaddr_i);
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_unc_load_mem: assert property (d_take && d_unc && !d_we_i && !d_flush_i |-> ##[2:60]
    mem_req_o && !mem_we_o && mem_addr_o == pa_q) else $error("unc load");
  a_unc_wait: assert property (d_take && d_unc && !d_flush_i |-> ##1 !d_ack_o [*2])
    else $error("unc ack early");
  a_st_mem_write: assert property (d_take && d_we_i && !d_flush_i && (d_unc || !d_wb_mode_i)
    |-> ##[2:60] mem_req_o && mem_we_o && mem_addr_o == pa_q && mem_be_o == be_q)
    else $error("store not in mem");
  a_part_slow: assert property (d_take && d_we_i && !d_flush_i && d_be_i != DMC_BE_FULL |=> !d_ack_o)
    else $error("partial ack early");
  a_wb_defer: assert property (d_busy_q && wbst_q && mem_req_o && mem_we_o |-> mem_addr_o != pa_q)
    else $error("wb store sent");
  a_part_bytes: assert property (d_busy_q && part_q && mem_req_o && mem_we_o
    |-> mem_be_o == be_q && mem_addr_o == pa_q) else $error("partial write bad");
  a_dack_pulse: assert property (d_ack_o |=> !d_ack_o) else $error("d ack long");
  a_iack_pulse: assert property (i_ack_o |=> !i_ack_o) else $error("i ack long");
  a_unc_fetch_mem: assert property (i_take && i_unc |-> ##[2:60]
    mem_req_o && !mem_we_o && mem_addr_o == ipa_q) else $error("unc fetch");
  c_partial: cover property (d_take && d_we_i && d_be_i != DMC_BE_FULL);
  c_flush: cover property (d_take && d_flush_i);
  c_parallel: cover property (d_take && i_take);
  c_evict: cover property (d_busy_q && wbst_q && mem_req_o && mem_we_o);
endmodule
bind dmc_cache_ctrl dmc_cache_ctrl_chk u_dmc_cache_ctrl_chk (.*);

// *** sim/test_dmc_cache_ctrl.sv ***
`timescale 1ns/1ps
module test_dmc_cache_ctrl;
  logic sys_clk_i = 0, reset_i = 1, d_req_i = 0, d_we_i = 0, d_flush_i = 0, d_wb_mode_i = 0, d_lock_i = 0;
  logic d_fill4_i = 0, i_req_i = 0, d_ack_o, i_ack_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [3:0] d_be_i = 0, mem_be_o;
  logic [31:0] d_vaddr_i = 0, d_wdata_i = 0, i_vaddr_i = 0, d_rdata_o, i_rdata_o, mem_addr_o, mem_wdata_o;
  logic [31:0] mem_rdata_i, rdat, idat;
  int fails = 0, checked = 0, lat, ilat, cyc = 0;
  localparam logic [31:0] A = 32'h8000_0040, B = 32'h8000_0100;
  dmc_cache_ctrl u_dmc_cache_ctrl (.*);
  dmc_mem_model u_dmc_mem_model (.sys_clk_i(sys_clk_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .be_i(mem_be_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] iv(input logic [31:0] a);
    return a ^ 32'h5a5a_0000;
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic dop(input logic we, fl, input logic [3:0] be, input logic [31:0] va, wd, input logic wb, lk);
    @(negedge sys_clk_i);
    d_req_i = 1'b1;
    d_we_i = we;
    d_flush_i = fl;
    d_be_i = be;
    d_vaddr_i = va;
    d_wdata_i = wd;
    d_wb_mode_i = wb;
    d_lock_i = lk;
    @(negedge sys_clk_i);
    for (lat = 1; d_ack_o !== 1'b1 && lat < 400; lat++) @(negedge sys_clk_i);
    rdat = d_rdata_o;
    @(negedge sys_clk_i);
    d_req_i = 1'b0;
  endtask
  task automatic iop(input logic [31:0] va);
    @(negedge sys_clk_i);
    i_req_i = 1'b1;
    i_vaddr_i = va;
    @(negedge sys_clk_i);
    for (ilat = 1; i_ack_o !== 1'b1 && ilat < 400; ilat++) @(negedge sys_clk_i);
    idat = i_rdata_o;
    @(negedge sys_clk_i);
    i_req_i = 1'b0;
  endtask
  task automatic t_load_unc;
    int r0;
    r0 = u_dmc_mem_model.nrd;
    dop(0, 0, 4'h0, A, 0, 0, 0);
    chk(rdat, iv(32'h40), "miss");
    dop(0, 0, 4'h0, A, 0, 0, 0);
    chk(lat, 1, "hit lat");
    chk(u_dmc_mem_model.nrd - r0, 1, "hit rd");
    u_dmc_mem_model.mem[32'h40] = 32'h1234_5678;
    dop(0, 0, 4'h0, 32'ha000_0040, 0, 0, 0);
    chk(rdat, 32'h1234_5678, "unc ld");
    dop(1, 0, 4'hf, 32'ha000_0040, 32'h600d_600d, 0, 0);
    chk(u_dmc_mem_model.rd(32'h40), 32'h600d_600d, "unc st");
    dop(0, 0, 4'h0, A, 0, 0, 0);
    chk(rdat, iv(32'h40), "untouched");
    $display("load ok");
  endtask
  task automatic t_store;
    int w0, r0;
    w0 = u_dmc_mem_model.nwr;
    dop(1, 0, 4'hf, A, 32'hcafe_0001, 0, 0);
    chk(u_dmc_mem_model.rd(32'h40), 32'hcafe_0001, "wt mem");
    dop(0, 0, 4'h0, A, 0, 0, 0);
    chk(rdat, 32'hcafe_0001, "st cache");
    dop(1, 0, 4'h1, A, 32'h0000_00ee, 0, 0);
    chk(u_dmc_mem_model.rd(32'h40), 32'hcafe_00ee, "part mem");
    dop(1, 0, 4'h2, A, 32'h0000_bb00, 1, 0);
    chk(lat, 2, "part lat");
    chk(u_dmc_mem_model.nwr - w0, 2, "wb part");
    dop(0, 0, 4'h0, A, 0, 0, 0);
    chk(rdat, 32'hcafe_bbee, "merged");
    r0 = u_dmc_mem_model.nrd;
    dop(1, 0, 4'h8, 32'h8000_0080, 32'h7700_0000, 0, 0);
    chk(u_dmc_mem_model.rd(32'h80), 32'h775a_0080, "pmiss mem");
    dop(0, 0, 4'h0, 32'h8000_0080, 0, 0, 0);
    chk(u_dmc_mem_model.nrd - r0, 1, "pmiss cache");
    $display("store ok");
  endtask
  task automatic t_wb;
    int w0;
    u_dmc_mem_model.lat = 3;
    w0 = u_dmc_mem_model.nwr;
    dop(1, 0, 4'hf, B, 32'h1111_2222, 1, 0);
    chk(lat, 1, "wb lat");
    chk(u_dmc_mem_model.rd(32'h100), iv(32'h100), "deferred");
    dop(0, 0, 4'h0, 32'h8000_0500, 0, 1, 0);
    chk(u_dmc_mem_model.rd(32'h100), 32'h1111_2222, "victim");
    chk(rdat, iv(32'h500), "refill");
    dop(0, 0, 4'h0, B, 0, 1, 0);
    chk(rdat, 32'h1111_2222, "replaced");
    chk(u_dmc_mem_model.nwr - w0, 1, "clean");
    dop(1, 0, 4'hf, B, 32'h3333_4444, 1, 0);
    dop(0, 1, 4'h0, B, 0, 1, 0);
    chk(u_dmc_mem_model.rd(32'h100), 32'h3333_4444, "flush");
    u_dmc_mem_model.lat = 0;
    $display("wb ok");
  endtask
  task automatic t_fill_lock;
    int r0;
    d_fill4_i = 1'b1;
    r0 = u_dmc_mem_model.nrd;
    dop(0, 0, 4'h0, 32'h8000_0300, 0, 0, 0);
    for (int k = 1; k < 4; k++) begin
      dop(0, 0, 4'h0, 32'h8000_0300 + 4 * k, 0, 0, 0);
      chk(rdat, iv(32'h300 + 4 * k), "burst");
    end
    chk(u_dmc_mem_model.nrd - r0, 4, "burst rd");
    d_fill4_i = 1'b0;
    dop(0, 0, 4'h0, 32'h8000_0200, 0, 0, 1);
    r0 = u_dmc_mem_model.nrd;
    dop(0, 0, 4'h0, 32'h8000_0600, 0, 0, 0);
    chk(rdat, iv(32'h600), "other");
    dop(0, 0, 4'h0, 32'h8000_0200, 0, 0, 0);
    chk(lat, 1, "kept");
    chk(u_dmc_mem_model.nrd - r0, 1, "lock rd");
    $display("lock ok");
  endtask
  task automatic t_fetch;
    int r0;
    r0 = u_dmc_mem_model.nrd;
    iop(32'h0000_1000);
    chk(idat, iv(32'h4000_1000), "mapped");
    chk(u_dmc_mem_model.nrd - r0, 4, "fill");
    fork
      iop(32'h0000_100c);
      dop(0, 0, 4'h0, A, 0, 0, 0);
    join
    chk(idat, iv(32'h4000_100c), "word");
    chk(ilat + lat, 2, "parallel");
    iop(32'ha000_2000);
    chk(idat, iv(32'h2000), "unc fetch");
    $display("fetch ok");
  endtask
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_load_unc();
    t_store();
    t_wb();
    t_fill_lock();
    t_fetch();
    end_sim();
  end
endmodule
